/* supply_event_interrupt_sources.sv */
// Supply event flags, supply source tracking and shared interrupt, with an AXI4-Lite slave.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "supply_irq_map.svh"

// Functional notes
// - Main-to-battery switch sets switchover flag, may interrupt.
// - Battery-to-main switch sets restore flag, may interrupt.
// - Both supply flags set regardless of enables.
// - Supply flags clear only by writing zero.
// - Config bit 6 reads one on main rail.
// - DC input change beyond delta raises event.
// - Background and software-started DC input conversions.
// - New DC input result sets ready flag.
// - Battery below threshold or new reading sets flag.
// - Battery event interrupts only when enabled.
// - DC input comparator low sets compare flag.
// - Comparator event interrupts only when enabled.
// - Line below level for cycle count sets flag.
// - Line dip event interrupts only when enabled.
// - Compare flag rises on the first synchronized low sample.
// - Low main rail switches to battery once synchronized, with no delay count.
// - Enabled low DC input switches after 30 ms.
// - Restore to main rail after 130 ms.
// - All events share one interrupt output.
// - Interrupt off after reset, gated by master enable.
module supply_event_interrupt_sources #(
  parameter int unsigned DCIN_SWITCH_CYCLES = `CLK_HZ / 1000 * `DCIN_SWITCH_MS,
  parameter int unsigned RESTORE_CYCLES     = `CLK_HZ / 1000 * `RESTORE_MS
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Analog comparator pins
  input  wire logic                 main_rail_low,
  input  wire logic                 dcin_below_ref,
  // Converter and metering results on this clock
  input  wire logic                 dcin_result_valid,
  input  wire logic [7:0]           dcin_result,
  input  wire logic                 bat_result_valid,
  input  wire logic [7:0]           bat_result,
  input  wire logic                 line_cycle_done,
  input  wire logic [7:0]           line_cycle_level,
  // Block outputs
  output logic                      dcin_conv_start,
  output logic                      on_battery,
  output logic                      power_management_irq
);
  import supply_irq_pkg::*;
  localparam int unsigned CW = 23;
  logic [9:0]  aw_idx_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic        wr_hit;
  logic        wr_lane0;
  byte_t       wr_byte;
  byte_t sag_cycle_count_q;
  byte_t sag_level_threshold_q;
  byte_t battery_adc_value_q;
  byte_t supply_irq_enable_q;
  byte_t temp_supply_delta_q;
  byte_t peripheral_config_store_q;
  byte_t supply_irq_flags_q;
  byte_t battery_threshold_q;
  logic  dcin_switch_en_q;
  logic  supply_irq_master_en_q;
  logic [1:0] vdd_low_sync_q;
  logic [1:0] dcin_low_sync_q;
  logic       vdd_low;
  logic       dcin_low;
  logic       dcin_low_prev_q;
  supply_state_t state_q;
  logic [CW-1:0] delay_cnt_q;
  logic          restore_ok;
  logic          to_battery;
  logic          to_main;
  logic [11:0] bg_cnt_q;
  logic        adc_start_wr;
  byte_t       dcin_ref_q;
  logic        dcin_ref_valid_q;
  byte_t       dcin_diff;
  logic        dcin_delta_ev;
  logic        bat_ev;
  byte_t       dip_cnt_q;
  logic        dip_armed_q;
  logic        dip_ev;
  byte_t       flag_set;

  assign vdd_low  = vdd_low_sync_q[1];
  assign dcin_low = dcin_low_sync_q[1];
  // Only the low byte lane carries register data; the upper lanes are ignored.
  assign wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb_q[0];
  assign wr_byte  = w_data_q[7:0];
  always_comb begin
    case (aw_idx_q)
      `IDX_SAG_CYCLE, `IDX_SAG_LEVEL, `IDX_ADC_START, `IDX_BAT_ADC, `IDX_IRQ_ENABLE,
      `IDX_SUPPLY_DELTA, `IDX_PERIPHERAL_CONFIG_CFG, `IDX_IRQ_FLAGS, `IDX_BAT_THRESH,
      `IDX_SWITCH_CFG, `IDX_IRQ_MASTER: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vdd_low_sync_q  <= 2'b00;
      dcin_low_sync_q <= 2'b00;
      dcin_low_prev_q <= 1'b0;
    end else begin
      vdd_low_sync_q  <= {vdd_low_sync_q[0], main_rail_low};
      dcin_low_sync_q <= {dcin_low_sync_q[0], dcin_below_ref};
      dcin_low_prev_q <= dcin_low;
    end
  end

  // Write address and data are taken in either order and held until the write completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_idx_q      <= 10'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sag_cycle_count_q      <= `RST_BYTE;
      sag_level_threshold_q  <= `RST_BYTE;
      supply_irq_enable_q    <= `RST_BYTE;
      temp_supply_delta_q    <= `RST_BYTE;
      peripheral_config_store_q         <= `RST_BYTE;
      battery_threshold_q    <= `RST_BYTE;
      dcin_switch_en_q       <= 1'b0;
      supply_irq_master_en_q <= 1'b0;
    end else if (wr_lane0) begin
      case (aw_idx_q)
        `IDX_SAG_CYCLE:    sag_cycle_count_q     <= wr_byte;
        `IDX_SAG_LEVEL:    sag_level_threshold_q <= wr_byte;
        `IDX_IRQ_ENABLE:   supply_irq_enable_q   <= wr_byte & `FLAG_MASK;
        `IDX_SUPPLY_DELTA: temp_supply_delta_q   <= wr_byte;
        `IDX_PERIPHERAL_CONFIG_CFG:   peripheral_config_store_q        <= wr_byte;
        `IDX_BAT_THRESH:   battery_threshold_q   <= wr_byte;
        `IDX_SWITCH_CFG:   dcin_switch_en_q      <= wr_byte[`BIT_DCIN_SWITCH_EN];
        `IDX_IRQ_MASTER:   supply_irq_master_en_q <= wr_byte[`BIT_MASTER_EN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr[11:2])
          `IDX_SAG_CYCLE:    s_axi_rdata[7:0] <= sag_cycle_count_q;
          `IDX_SAG_LEVEL:    s_axi_rdata[7:0] <= sag_level_threshold_q;
          `IDX_ADC_START:    s_axi_rdata[7:0] <= `RST_BYTE;
          `IDX_BAT_ADC:      s_axi_rdata[7:0] <= battery_adc_value_q;
          `IDX_IRQ_ENABLE:   s_axi_rdata[7:0] <= supply_irq_enable_q;
          `IDX_SUPPLY_DELTA: s_axi_rdata[7:0] <= temp_supply_delta_q;
          `IDX_PERIPHERAL_CONFIG_CFG: begin
            s_axi_rdata[7:0]                <= peripheral_config_store_q;
            s_axi_rdata[`BIT_SUPPLY_SOURCE] <= (state_q == SRC_MAIN);
          end
          `IDX_IRQ_FLAGS:    s_axi_rdata[7:0] <= supply_irq_flags_q;
          `IDX_BAT_THRESH:   s_axi_rdata[7:0] <= battery_threshold_q;
          `IDX_SWITCH_CFG:   s_axi_rdata[`BIT_DCIN_SWITCH_EN] <= dcin_switch_en_q;
          `IDX_IRQ_MASTER:   s_axi_rdata[`BIT_MASTER_EN] <= supply_irq_master_en_q;
          default:           s_axi_rresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign restore_ok = !vdd_low && (!dcin_switch_en_q || !dcin_low);
  assign to_battery = (state_q == SRC_MAIN) && (vdd_low ||
                      (dcin_switch_en_q && dcin_low &&
                       delay_cnt_q == CW'(DCIN_SWITCH_CYCLES - 1)));
  assign to_main    = (state_q == SRC_BATTERY) && restore_ok &&
                      delay_cnt_q == CW'(RESTORE_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= SRC_MAIN;
      delay_cnt_q <= '0;
    end else begin
      case (state_q)
        SRC_MAIN: begin
          if (to_battery) begin
            state_q     <= SRC_BATTERY;
            delay_cnt_q <= '0;
          end else if (dcin_switch_en_q && dcin_low) begin
            delay_cnt_q <= delay_cnt_q + 1'b1;
          end else begin
            delay_cnt_q <= '0;
          end
        end
        SRC_BATTERY: begin
          if (to_main) begin
            state_q     <= SRC_MAIN;
            delay_cnt_q <= '0;
          end else if (restore_ok) begin
            delay_cnt_q <= delay_cnt_q + 1'b1;
          end else begin
            delay_cnt_q <= '0;
          end
        end
        default: begin
          state_q     <= SRC_MAIN;
          delay_cnt_q <= '0;
        end
      endcase
    end
  end

  // Background conversions restart their interval after a software start.
  assign adc_start_wr = wr_lane0 && aw_idx_q == `IDX_ADC_START;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bg_cnt_q        <= 12'h000;
      dcin_conv_start <= 1'b0;
    end else begin
      dcin_conv_start <= adc_start_wr || bg_cnt_q == `BG_PERIOD_CYCLES - 12'h001;
      if (adc_start_wr || bg_cnt_q == `BG_PERIOD_CYCLES - 12'h001) begin
        bg_cnt_q <= 12'h000;
      end else begin
        bg_cnt_q <= bg_cnt_q + 12'h001;
      end
    end
  end
  assign dcin_diff     = (dcin_result > dcin_ref_q) ? dcin_result - dcin_ref_q
                                                    : dcin_ref_q - dcin_result;
  assign dcin_delta_ev = dcin_result_valid && dcin_ref_valid_q &&
                         dcin_diff > temp_supply_delta_q;
  assign bat_ev        = bat_result_valid;
  assign dip_ev        = line_cycle_done && line_cycle_level < sag_level_threshold_q &&
                         dip_armed_q && dip_cnt_q + 8'h01 >= sag_cycle_count_q;

  // The first reading only seeds the reference, so no change is claimed from reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcin_ref_q          <= `RST_BYTE;
      dcin_ref_valid_q    <= 1'b0;
      battery_adc_value_q <= `RST_BYTE;
    end else begin
      if (dcin_result_valid) begin
        dcin_ref_q       <= dcin_result;
        dcin_ref_valid_q <= 1'b1;
      end
      if (bat_result_valid) begin
        battery_adc_value_q <= bat_result;
      end
    end
  end

  // A dip is reported once per run of low cycles; a level at or above the threshold rearms it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dip_cnt_q   <= 8'h00;
      dip_armed_q <= 1'b1;
    end else if (line_cycle_done) begin
      if (line_cycle_level >= sag_level_threshold_q) begin
        dip_cnt_q   <= 8'h00;
        dip_armed_q <= 1'b1;
      end else if (dip_ev) begin
        dip_armed_q <= 1'b0;
      end else if (dip_armed_q) begin
        dip_cnt_q <= dip_cnt_q + 8'h01;
      end
    end
  end

  // Flags set whatever the enables; a set in the cycle of a clear wins.
  always_comb begin
    flag_set                     = 8'h00;
    flag_set[`BIT_DCIN_COMPARE]  = dcin_low && !dcin_low_prev_q;
    flag_set[`BIT_BATTERY]       = bat_ev ||
                                   (bat_result_valid && bat_result < battery_threshold_q);
    flag_set[`BIT_DCIN_ADC]      = dcin_delta_ev;
    flag_set[`BIT_DCIN_READY]    = dcin_result_valid;
    flag_set[`BIT_LINE_DIP]      = dip_ev;
    flag_set[`BIT_RESTORE]       = to_main;
    flag_set[`BIT_SWITCHOVER]    = to_battery;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_irq_flags_q <= `RST_BYTE;
    end else if (wr_lane0 && aw_idx_q == `IDX_IRQ_FLAGS) begin
      supply_irq_flags_q <= (supply_irq_flags_q & wr_byte & `FLAG_MASK) | flag_set;
    end else begin
      supply_irq_flags_q <= supply_irq_flags_q | flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_management_irq <= 1'b0;
      on_battery           <= 1'b0;
    end else begin
      power_management_irq <= supply_irq_master_en_q &&
                              |(supply_irq_flags_q & supply_irq_enable_q);
      on_battery           <= to_battery || (on_battery && !to_main);
    end
  end

endmodule

/* supply_event_interrupt_sources_tb.sv */
// Self-checking bench for the supply event block.
`timescale 1ns/1ps
`include "supply_irq_map.svh"
module supply_event_interrupt_sources_tb;
  logic aclk = 0, aresetn = 0, bat_go = 0, main_rail_low = 0, dcin_below_ref = 0, slow = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dcin_result_valid, bat_result_valid, line_cycle_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] dcin_result, bat_result, line_cycle_level;
  logic [7:0] dcin_level = 8'h40, bat_level = 8'h20, line_level = 8'hff;
  logic dcin_conv_start, on_battery, power_management_irq;
  int bad_count = 0, n_checks = 0, conv_n = 0;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (dcin_conv_start === 1'b1) conv_n++;
  supply_event_interrupt_sources #(.DCIN_SWITCH_CYCLES(20), .RESTORE_CYCLES(30)) dut (.*);
  supply_irq_front_model model (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // A slow master leaves the response waiting one cycle to prove the slave holds it.
    if (slow) begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    if (slow) begin
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_reset;
    rd(`IDX_PERIPHERAL_CONFIG_CFG);
    chk("source", 1, rv[6]);
    chk("irq", 0, power_management_irq);
    slow = 1'b1;
    rd(10'h001);
    chk("unmapped", 2'b10, rsp);
    wr(10'h001, 8'h5a);
    chk("wr_unmapped", 2'b10, rsp);
    slow = 1'b0;
    wr(`IDX_IRQ_MASTER, 8'h01);
    chk("wr_ok", 2'b00, rsp);
    wr(`IDX_IRQ_FLAGS, 8'h00);
  endtask
  task automatic t_switch;
    wr(`IDX_IRQ_ENABLE, 8'h40);
    main_rail_low <= 1'b1;
    cyc(8);
    chk("on_battery", 1, on_battery);
    rd(`IDX_IRQ_FLAGS);
    chk("switchover", 1, rv[6]);
    chk("irq", 1, power_management_irq);
    rd(`IDX_PERIPHERAL_CONFIG_CFG);
    chk("source", 0, rv[6]);
    wr(`IDX_IRQ_FLAGS, 8'hff);
    rd(`IDX_IRQ_FLAGS);
    chk("kept", 1, rv[6]);
    wr(`IDX_IRQ_FLAGS, 8'h00);
    cyc(3);
    chk("irq", 0, power_management_irq);
    main_rail_low <= 1'b0;
    cyc(20);
    chk("early", 1, on_battery);
    cyc(20);
    chk("restored", 0, on_battery);
    rd(`IDX_IRQ_FLAGS);
    chk("restore", 2'b01, rv[6:5]);
    chk("irq", 0, power_management_irq);
    wr(`IDX_IRQ_ENABLE, 8'h20);
    cyc(3);
    chk("irq", 1, power_management_irq);
    wr(`IDX_IRQ_FLAGS, 8'h00);
  endtask
  task automatic t_battery;
    wr(`IDX_IRQ_ENABLE, 8'h00);
    bat_go <= 1'b1;
    @(posedge aclk);
    bat_go <= 1'b0;
    cyc(4);
    rd(`IDX_IRQ_FLAGS);
    chk("battery", 1, rv[1]);
    chk("irq", 0, power_management_irq);
    rd(`IDX_BAT_ADC);
    chk("bat_value", 8'h20, rv);
    wr(`IDX_IRQ_ENABLE, 8'h02);
    cyc(3);
    chk("irq", 1, power_management_irq);
    wr(`IDX_IRQ_MASTER, 8'h00);
    cyc(3);
    chk("irq", 0, power_management_irq);
    wr(`IDX_IRQ_MASTER, 8'h01);
    wr(`IDX_IRQ_FLAGS, 8'h00);
  endtask
  task automatic t_dcin;
    logic [7:0] lv[3] = '{8'h40, 8'h50, 8'h61};
    int c;
    wr(`IDX_IRQ_ENABLE, 8'h04);
    wr(`IDX_SUPPLY_DELTA, 8'h10);
    s_axi_wstrb <= 4'h0;
    wr(`IDX_SUPPLY_DELTA, 8'h55);
    s_axi_wstrb <= 4'h1;
    chk("strb_ok", 2'b00, rsp);
    rd(`IDX_SUPPLY_DELTA);
    chk("delta_reg", 8'h10, rv);
    for (int k = 0; k < 3; k++) begin
      dcin_level <= lv[k];
      wr(`IDX_IRQ_FLAGS, 8'h00);
      c = conv_n;
      wr(`IDX_ADC_START, 8'h01);
      cyc(8);
      chk("started", c + 1, conv_n);
      rd(`IDX_IRQ_FLAGS);
      chk("ready", 1, rv[3]);
      chk("delta", k == 2, rv[2]);
    end
    chk("irq", 1, power_management_irq);
    c = conv_n;
    cyc(4000);
    chk("background", c + 1, conv_n);
    wr(`IDX_IRQ_FLAGS, 8'h00);
  endtask
  task automatic t_compare;
    wr(`IDX_IRQ_ENABLE, 8'h00);
    wr(`IDX_SWITCH_CFG, 8'h01);
    dcin_below_ref <= 1'b1;
    cyc(10);
    chk("early", 0, on_battery);
    cyc(20);
    chk("on_battery", 1, on_battery);
    rd(`IDX_IRQ_FLAGS);
    chk("compare", 1, rv[0]);
    chk("irq", 0, power_management_irq);
    wr(`IDX_IRQ_ENABLE, 8'h01);
    cyc(3);
    chk("irq", 1, power_management_irq);
    dcin_below_ref <= 1'b0;
    cyc(45);
    chk("restored", 0, on_battery);
    wr(`IDX_SWITCH_CFG, 8'h00);
    wr(`IDX_IRQ_FLAGS, 8'h00);
  endtask
  task automatic t_dip;
    wr(`IDX_IRQ_ENABLE, 8'h10);
    wr(`IDX_SAG_CYCLE, 8'h03);
    line_level <= 8'h90;
    wr(`IDX_SAG_LEVEL, 8'h80);
    cyc(40);
    line_level <= 8'h70;
    cyc(6);
    rd(`IDX_IRQ_FLAGS);
    chk("dip_early", 0, rv[4]);
    cyc(24);
    rd(`IDX_IRQ_FLAGS);
    chk("dip", 1, rv[4]);
    chk("irq", 1, power_management_irq);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // The run needs about 5000 cycles; four times that means a hang.
  initial begin
    #(25 * 20000);
    bad_count++;
    print_verdict();
  end
  initial begin
    cyc(12);
    aresetn <= 1'b1;
    t_reset();
    t_switch();
    t_battery();
    t_dcin();
    t_compare();
    t_dip();
    print_verdict();
  end
endmodule

/* supply_irq_assertions.sv */
// Port-level checks of the supply event block.
`timescale 1ns/1ps
module supply_irq_checker #(
  parameter int unsigned DCIN_SWITCH_CYCLES = 20,
  parameter int unsigned RESTORE_CYCLES     = 30
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        main_rail_low,
  input wire logic        dcin_conv_start,
  input wire logic        on_battery,
  input wire logic        power_management_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  irq_reset_off_a: assert property ($rose(aresetn) |-> !power_management_irq)
    else $error("interrupt high at reset release");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  busy_ready_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  rail_switch_a: assert property ($rose(main_rail_low) && !on_battery |-> ##[2:6] on_battery)
    else $error("no switch to battery after low rail");
  restore_good_a: assert property ($fell(on_battery) |-> !main_rail_low && !$past(main_rail_low, 8))
    else $error("restore while rail low");
  conv_pulse_a: assert property (dcin_conv_start |=> !dcin_conv_start)
    else $error("conversion start not a pulse");
  cover property ($rose(on_battery));
  cover property ($fell(on_battery));
  cover property ($rose(power_management_irq));
endmodule

bind supply_event_interrupt_sources supply_irq_checker #(
  .DCIN_SWITCH_CYCLES(DCIN_SWITCH_CYCLES),
  .RESTORE_CYCLES(RESTORE_CYCLES)
) chk (.*);

/* supply_irq_front_model.sv */
// Behavioural converter and metering front end that feeds the supply event block.
`timescale 1ns/1ps
module supply_irq_front_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Conversion start from the block; battery request and levels set by the bench
  input  wire logic       dcin_conv_start,
  input  wire logic [7:0] dcin_level,
  input  wire logic       bat_go,
  input  wire logic [7:0] bat_level,
  input  wire logic [7:0] line_level,
  // Results toward the block
  output logic            dcin_result_valid,
  output logic [7:0]      dcin_result,
  output logic            bat_result_valid,
  output logic [7:0]      bat_result,
  output logic            line_cycle_done,
  output logic [7:0]      line_cycle_level
);
  logic [2:0] wait_q;
  logic [2:0] line_q;
  // A request made while a conversion runs is dropped, as a busy converter would.
  // Data lines toggle outside their valid cycle so stale values never match by luck.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q            <= 3'h0;
      line_q            <= 3'h0;
      dcin_result_valid <= 1'b0;
      bat_result_valid  <= 1'b0;
      line_cycle_done   <= 1'b0;
      dcin_result       <= 8'h00;
      bat_result        <= 8'h00;
      line_cycle_level  <= 8'h00;
    end else begin
      dcin_result_valid <= (wait_q == 3'h1);
      dcin_result       <= (wait_q == 3'h1) ? dcin_level : ~dcin_result;
      if (dcin_conv_start && wait_q == 3'h0) wait_q <= 3'h3;
      else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
      bat_result_valid  <= bat_go;
      bat_result        <= bat_go ? bat_level : ~bat_result;
      line_q            <= line_q + 3'h1;
      line_cycle_done   <= (line_q == 3'h7);
      line_cycle_level  <= (line_q == 3'h7) ? line_level : ~line_cycle_level;
    end
  end
endmodule

/* supply_irq_map.svh */
// Register indices, field positions, reset values and timing figures of the supply event block.
`ifndef SUPPLY_IRQ_MAP_SVH
`define SUPPLY_IRQ_MAP_SVH

`define IDX_SAG_CYCLE      10'h013
`define IDX_SAG_LEVEL      10'h014
`define IDX_ADC_START      10'h0d8
`define IDX_BAT_ADC        10'h0df
`define IDX_IRQ_ENABLE     10'h0ec
`define IDX_SUPPLY_DELTA   10'h0f3
`define IDX_PERIPHERAL_CONFIG_CFG     10'h0f4
`define IDX_IRQ_FLAGS      10'h0f8
`define IDX_BAT_THRESH     10'h0fa
`define IDX_SWITCH_CFG     10'h100
`define IDX_IRQ_MASTER     10'h101

`define BIT_DCIN_COMPARE   0
`define BIT_BATTERY        1
`define BIT_DCIN_ADC       2
`define BIT_DCIN_READY     3
`define BIT_LINE_DIP       4
`define BIT_RESTORE        5
`define BIT_SWITCHOVER     6
`define BIT_SUPPLY_SOURCE  6
`define BIT_DCIN_SWITCH_EN 0
`define BIT_MASTER_EN      0

`define FLAG_MASK          8'h7f
`define RST_BYTE           8'h00
`define RST_SRC_MAIN       1'b1
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`define CLK_HZ             40000000
`define DCIN_SWITCH_MS     30
`define RESTORE_MS         130
`define BG_PERIOD_CYCLES   12'hfa0

`endif

/* supply_irq_pkg.sv */
// Types shared by the supply event block.
package supply_irq_pkg;
  typedef enum logic [1:0] {
    SRC_MAIN    = 2'b01,
    SRC_BATTERY = 2'b10
  } supply_state_t;
  typedef logic [7:0] byte_t;
endpackage
